// ---- common/flash_front_consts.svh ----
/*
 constants for the serial flash pin front end.
 assumes inclusion by bare name from the design file.
*/
`ifndef FLASH_FRONT_CONSTS_SVH
`define FLASH_FRONT_CONSTS_SVH
`define LANE_SINGLE 2'h0
`define LANE_DUAL 2'h1
`define LANE_QUAD 2'h2
`define PAUSE_SELECT_HOLD 1'h0
`define SHIFT_WIDTH 8
`endif

// ---- common/flash_front_pkg.sv ----
/*
 types shared by the serial flash pin front end.
 does not include the constants header; the lane codes repeat its values.
*/
package flash_front_pkg;
    typedef enum logic [1:0] {
        lanes_single = 2'h0,
        lanes_dual = 2'h1,
        lanes_quad = 2'h2
    } lane_mode_t;

    typedef struct packed {
        logic status_protect_bit_one;
        logic status_protect_bit_zero;
        logic quad_enable;
        logic pause_or_reset_select;
    } status_cfg_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } lane_drive_t;
endpackage

// ---- dv/host_model.sv ----
/*
 host serial controller model: drives select, serial clock and the four lanes.
 assumes the bench calls its tasks in sequence and reads nothing back from it.
*/
`timescale 1ns/1ps
module host_model (
    output logic select_n,
    output logic serial_clock,
    output logic [3:0] lane_in
);
    logic idle_lvl = 1'b0;
    // lanes 2 and 3 rest at their pull-up level
    initial begin
        select_n = 1'b1;
        serial_clock = 1'b0;
        lane_in = 4'hc;
    end
    task automatic set_idle(input logic v);
        idle_lvl = v;
        serial_clock = v;
    endtask
    task automatic set_clock(input logic v);
        serial_clock = v;
    endtask
    task automatic set_pin(input int idx, input logic v);
        lane_in[idx] = v;
    endtask
    task automatic open_frame();
        select_n = 1'b0;
        #100;
    endtask
    // msb first; the upper lane carries the higher bit
    task automatic send(input logic [7:0] b, input int bpr);
        logic [7:0] v;
        logic [3:0] m;
        m = 4'((1 << bpr) - 1);
        for (int i = 8; i > 0; i -= bpr) begin
            serial_clock = 1'b0;
            v = b >> (i - bpr);
            lane_in = (lane_in & ~m) | (v[3:0] & m);
            #100 serial_clock = 1'b1;
            #100;
        end
        serial_clock = idle_lvl;
    endtask
    task automatic close_frame();
        serial_clock = idle_lvl;
        #100 select_n = 1'b1;
        // released data lanes have no pull, so they must not keep their last value
        lane_in[1:0] = ~lane_in[1:0];
        #100;
    endtask
endmodule // host_model

// ---- dv/tb_top.sv ----
/*
 testbench for the serial flash pin front end.
 assumes host_model drives the pins and the instruction layer inputs come from here.
*/
`timescale 1ns/1ps
module tb_top;
    import flash_front_pkg::*;
    typedef struct packed {
        logic wp, s1, s0, qe, rg;
        lane_mode_t md;
        logic sw, aw;
        logic [3:0] oe;
        logic qr;
    } row_t;
    logic clk = 1'b0, rst_n = 1'b0, drive_data = 1'b0, busy = 1'b0, rg = 1'b1;
    logic sw_req = 1'b1, aw_req = 1'b1;
    logic select_n, serial_clock, selected, standby, frame_start, sample_pulse, shift_pulse;
    logic paused, pin_reset, sw_ok, aw_ok, q_ref;
    logic [3:0] lane_in, lane_out, lane_oe, sample_bits;
    logic [3:0] out_bits = 4'h9;
    logic [7:0] shift_q, held;
    status_cfg_t cfg = '0;
    lane_mode_t mode = lanes_single;
    int n_fail = 0, n_checks = 0;
    row_t rows[5] = '{
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, lanes_single, 1'b0, 1'b0, 4'h2, 1'b0},
        '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, lanes_dual, 1'b1, 1'b1, 4'h3, 1'b0},
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, lanes_single, 1'b1, 1'b1, 4'h2, 1'b0},
        '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, lanes_quad, 1'b1, 1'b1, 4'hf, 1'b0},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, lanes_quad, 1'b0, 1'b1, 4'h0, 1'b1}};
    always #12.5 clk = ~clk;
    host_model host_model_inst (.select_n(select_n), .serial_clock(serial_clock), .lane_in(lane_in));
    serial_flash_pin_front_end serial_flash_pin_front_end_inst (.clk(clk), .rst_n(rst_n),
        .select_n(select_n), .serial_clock(serial_clock), .lane_in(lane_in), .lane_out(lane_out),
        .lane_oe(lane_oe), .status_cfg(cfg), .lane_mode(mode), .drive_data(drive_data),
        .out_bits(out_bits), .embedded_busy(busy), .status_write_req(sw_req), .array_write_req(aw_req),
        .region_protected(rg), .selected(selected), .standby(standby), .frame_start(frame_start),
        .sample_pulse(sample_pulse), .sample_bits(sample_bits), .shift_pulse(shift_pulse),
        .shift_q(shift_q), .paused(paused), .pin_reset(pin_reset), .status_write_ok(sw_ok),
        .array_write_ok(aw_ok), .quad_refused(q_ref));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
    initial begin
        tick(3);
        chk("reset_oe", 8'h0, {4'h0, lane_oe});
        rst_n = 1'b1;
        tick(4);
        chk("idle_standby", 8'h1, {7'h0, standby});
        host_model_inst.open_frame();
        for (int i = 0; i < 10 && selected !== 1'b1; i++) tick(1);
        chk("selected", 8'h1, {7'h0, selected});
        chk("active", 8'h0, {7'h0, standby});
        drive_data = 1'b1;
        foreach (rows[i]) begin
            cfg = '{rows[i].s1, rows[i].s0, rows[i].qe, 1'b0};
            mode = rows[i].md;
            rg = rows[i].rg;
            host_model_inst.set_pin(2, rows[i].wp);
            // one clock pulse so the drive enables follow the new mode
            host_model_inst.set_clock(1'b1);
            tick(6);
            host_model_inst.set_clock(1'b0);
            tick(6);
            chk("status_write_ok", 8'(rows[i].sw), 8'(sw_ok));
            chk("array_write_ok", 8'(rows[i].aw), 8'(aw_ok));
            chk("lane_oe", 8'(rows[i].oe), 8'(lane_oe));
            chk("quad_refused", 8'(rows[i].qr), 8'(q_ref));
        end
        sw_req = 1'b0;
        aw_req = 1'b0;
        tick(2);
        chk("no_req_ok", 8'h0, {6'h0, sw_ok, aw_ok});
        sw_req = 1'b1;
        aw_req = 1'b1;
        cfg = 4'h2; // quad enable set before quad traffic
        for (int m = 0; m < 3; m++) begin
            mode = lane_mode_t'(m);
            out_bits = 4'h9 ^ 4'(m);
            host_model_inst.send(8'ha5 ^ 8'(m), 1 << m);
            tick(6);
            chk("shift_q", 8'ha5 ^ 8'(m), shift_q);
            chk("sample_bits", (8'ha5 ^ 8'(m)) & 8'((1 << (1 << m)) - 1), {4'h0, sample_bits});
            chk("lane_out", {4'h0, 4'h9 ^ 4'(m)}, {4'h0, lane_out});
            chk("no_pause_quad", 8'h0, {7'h0, paused});
        end
        host_model_inst.set_idle(1'b1);
        mode = lanes_single;
        host_model_inst.send(8'h3c, 1);
        tick(6);
        chk("shift_idle_high", 8'h3c, shift_q);
        cfg = '0;
        host_model_inst.set_pin(2, 1'b1);
        host_model_inst.set_pin(3, 1'b0);
        tick(8);
        chk("pause_wait", 8'h0, {7'h0, paused});
        host_model_inst.set_clock(1'b0);
        tick(8);
        chk("pause_on", 8'h1, {7'h0, paused});
        chk("pause_oe", 8'h0, {4'h0, lane_oe});
        held = shift_q;
        host_model_inst.set_clock(1'b1);
        host_model_inst.set_pin(3, 1'b1);
        tick(8);
        chk("pause_keep", held, shift_q);
        chk("pause_hold", 8'h1, {7'h0, paused});
        host_model_inst.set_clock(1'b0);
        tick(8);
        chk("pause_off", 8'h0, {7'h0, paused});
        cfg.pause_or_reset_select = 1'b1;
        host_model_inst.set_pin(3, 1'b0);
        tick(8);
        chk("pin_reset", 8'h1, {7'h0, pin_reset});
        cfg.quad_enable = 1'b1;
        tick(2);
        chk("pin_reset_qe", 8'h0, {7'h0, pin_reset});
        host_model_inst.set_pin(3, 1'b1);
        host_model_inst.close_frame();
        tick(8);
        chk("deselect_oe", 8'h0, {3'h0, selected, lane_oe});
        busy = 1'b1;
        tick(2);
        chk("busy_active", 8'h0, {7'h0, standby});
        end_sim();
    end
endmodule // tb_top

// ---- src/serial_flash_pin_front_end.sv ----
/*
 serial flash pin front end: select, power state, clock edge detection,
 lane steering for single/dual/quad, protect pin locking, pause and reset pin.
 assumes the host drives the serial clock and select, both slow against clk,
 and that the instruction layer supplies lane mode, output bits and status.
*/
`timescale 1ns/1ps
`include "flash_front_consts.svh"

module serial_flash_pin_front_end #(
    parameter int shift_width = `SHIFT_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic select_n,
    input wire logic serial_clock,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe,
    input wire flash_front_pkg::status_cfg_t status_cfg,
    input wire flash_front_pkg::lane_mode_t lane_mode,
    input wire logic drive_data,
    input wire logic [3:0] out_bits,
    input wire logic embedded_busy,
    input wire logic status_write_req,
    input wire logic array_write_req,
    input wire logic region_protected,
    output logic selected,
    output logic standby,
    output logic frame_start,
    output logic sample_pulse,
    output logic [3:0] sample_bits,
    output logic shift_pulse,
    output logic [shift_width-1:0] shift_q,
    output logic paused,
    output logic pin_reset,
    output logic status_write_ok,
    output logic array_write_ok,
    output logic quad_refused
);
    import flash_front_pkg::*;

    logic [1:0] cs_sync_q, sck_sync_q;
    logic [3:0] lane_sync0_q, lane_sync1_q;
    logic cs_n, sck, sck_prev_q, cs_prev_q, armed_q;
    logic sck_rise, sck_fall, pin_locked, pause_pin;
    logic pause_q;
    lane_drive_t drive_q;

    // two flops per pin input before any logic reads it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_sync_q <= 2'h3;
            sck_sync_q <= 2'h0;
            lane_sync0_q <= 4'hf;
            lane_sync1_q <= 4'hf;
        end else begin
            cs_sync_q <= {cs_sync_q[0], select_n};
            sck_sync_q <= {sck_sync_q[0], serial_clock};
            lane_sync0_q <= lane_in;
            lane_sync1_q <= lane_sync0_q;
        end
    end

    assign cs_n = cs_sync_q[1];
    assign sck = sck_sync_q[1];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_prev_q <= 1'h0;
            cs_prev_q <= 1'h1;
        end else begin
            sck_prev_q <= sck;
            cs_prev_q <= cs_n;
        end
    end

    // edges only count while selected; idle level of the clock is irrelevant
    assign sck_rise = sck & ~sck_prev_q;
    assign sck_fall = ~sck & sck_prev_q;
    assign frame_start = cs_prev_q & ~cs_n & armed_q;

    // nothing is accepted until the synchronized select (reset loads it high) has been high then falling after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_q <= 1'h0;
        end else if (cs_n) begin
            armed_q <= 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            selected <= 1'h0;
        end else if (cs_n) begin
            selected <= 1'h0;
        end else if (frame_start) begin
            selected <= 1'h1;
        end
    end

    assign standby = ~selected & ~embedded_busy;

    // protect pin and shared pause/reset pin functions
    assign pin_locked = ~lane_sync1_q[2] & ~status_cfg.status_protect_bit_one
        & status_cfg.status_protect_bit_zero & ~status_cfg.quad_enable;
    assign status_write_ok = status_write_req & ~pin_locked;
    assign array_write_ok = array_write_req & ~(pin_locked & region_protected);
    assign quad_refused = (lane_mode == lanes_quad) & ~status_cfg.quad_enable;

    assign pause_pin = ~status_cfg.quad_enable
        & (status_cfg.pause_or_reset_select == `PAUSE_SELECT_HOLD);
    assign pin_reset = ~status_cfg.quad_enable
        & (status_cfg.pause_or_reset_select != `PAUSE_SELECT_HOLD)
        & ~lane_sync1_q[3];

    // pause state follows the pin only while the serial clock is low, so a change
    // of the pin with clock high waits for the clock to fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pause_q <= 1'h0;
        end else if (cs_n | ~pause_pin) begin
            pause_q <= 1'h0;
        end else if (~sck) begin
            pause_q <= ~lane_sync1_q[3];
        end
    end

    assign paused = pause_q;

    // sampling on rising clock edges; lanes taken depend on mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample_pulse <= 1'h0;
            sample_bits <= 4'h0;
            shift_q <= '0;
        end else begin
            sample_pulse <= 1'h0;
            if (selected && !cs_n && !pause_q && !pin_reset && sck_rise) begin
                sample_pulse <= 1'h1;
                case (lane_mode)
                    lanes_single: begin
                        sample_bits <= {3'h0, lane_sync1_q[0]};
                        shift_q <= {shift_q[shift_width-2:0], lane_sync1_q[0]};
                    end
                    lanes_dual: begin
                        sample_bits <= {2'h0, lane_sync1_q[1:0]};
                        shift_q <= {shift_q[shift_width-3:0], lane_sync1_q[1:0]};
                    end
                    lanes_quad: begin
                        sample_bits <= lane_sync1_q;
                        shift_q <= {shift_q[shift_width-5:0], lane_sync1_q};
                    end
                    default: begin
                        sample_bits <= 4'h0;
                    end
                endcase
            end
        end
    end

    // output drive loads only on falling edges and clears at once while deselected or in pin reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_q <= '0;
            shift_pulse <= 1'h0;
        end else begin
            shift_pulse <= 1'h0;
            if (cs_n || !selected || pin_reset) begin
                drive_q <= '0;
            end else if (sck_fall && !pause_q) begin
                shift_pulse <= 1'h1;
                drive_q.out <= out_bits;
                if (!drive_data) begin
                    drive_q.oe <= 4'h0;
                end else begin
                    case (lane_mode)
                        lanes_single: drive_q.oe <= 4'h2;
                        lanes_dual: drive_q.oe <= 4'h3;
                        lanes_quad: drive_q.oe <= status_cfg.quad_enable ? 4'hf : 4'h0;
                        default: drive_q.oe <= 4'h0;
                    endcase
                end
            end
        end
    end

    // paused output floats at once but keeps the pending bits for resume
    assign lane_out = drive_q.out;
    assign lane_oe = (pause_q | cs_n) ? 4'h0 : drive_q.oe;

    tristate_deselect_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n |-> lane_oe == 4'h0) else $error("lanes driven while deselected");
    standby_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!selected && !embedded_busy) |-> standby) else $error("no standby when idle");
    select_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_start |=> selected) else $error("select fall not taken");
    armed_first_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(selected) |-> $past(armed_q)) else $error("selected without falling edge");
    sample_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        sample_pulse |-> $past(sck_rise)) else $error("sample off rising edge");
    status_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pin_locked && status_write_req) |-> !status_write_ok) else $error("locked status write");
    quad_no_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        status_cfg.quad_enable |-> !pin_locked && !pin_reset && !pause_q) else $error("pin function in quad");
    pause_clock_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(pause_q) && !cs_n && pause_pin |-> $past(!sck)) else $error("pause moved with clock high");
    pause_float_a: assert property (@(posedge clk) disable iff (!rst_n)
        pause_q |-> lane_oe == 4'h0 && !sample_pulse) else $error("activity during pause");
endmodule // serial_flash_pin_front_end
